// ---- hw/rscr_defines.vh ----
// Register offsets, field positions, reset values and codes of the regulator register bank.
`ifndef RSCR_DEFINES_VH
`define RSCR_DEFINES_VH
`define RSCR_ADDR_STATUS_BYTE 8'h78
`define RSCR_ADDR_STATUS_WORD 8'h79
`define RSCR_ADDR_VOUT_CMD 8'h21
`define RSCR_ADDR_VOUT_STATUS 8'h7A
`define RSCR_ADDR_IOUT_STATUS 8'h7B
`define RSCR_ADDR_INPUT_STATUS 8'h7C
`define RSCR_ADDR_THERM_STATUS 8'h7D
`define RSCR_ADDR_COMM_STATUS 8'h7E
`define RSCR_ADDR_LOCK 8'hC4
`define RSCR_ADDR_RETRY 8'hC5
`define RSCR_ADDR_START_RAMP 8'hC6
`define RSCR_ADDR_STOP_RAMP 8'hC7
`define RSCR_ADDR_TRANS_RAMP 8'hC8
`define RSCR_ADDR_DISCHARGE 8'hC9
`define RSCR_ADDR_SPREAD 8'hCA
`define RSCR_ADDR_FREQ 8'hCB
`define RSCR_ADDR_LOOP 8'hCC
`define RSCR_ADDR_PROTECT 8'hCE
`define RSCR_LOCK_CODE 8'h5A
`define RSCR_LOCK_CLEAR 8'h00
`define RSCR_RST_LOCK 8'h00
`define RSCR_RST_RETRY 2'h1
`define RSCR_RST_RAMP 2'h0
`define RSCR_RST_DISCHARGE 2'h0
`define RSCR_RST_SPREAD 1'h1
`define RSCR_RST_PHASE 1'h1
`define RSCR_RST_FREQ 2'h0
`define RSCR_RST_LOOP 10'h000
`define RSCR_RST_OVP_EN 1'h1
`define RSCR_RST_OCP_SEL 2'h3
`define RSCR_RST_VOUT_CMD 8'h7F
`define RSCR_BIT_POWER_LOW 11
`define RSCR_BIT_VOUT_OV 7
`define RSCR_BIT_VOUT_UV 4
`define RSCR_BIT_VOUT_LIMIT 3
`define RSCR_BIT_IOUT_OC 7
`define RSCR_BIT_VIN_OV 7
`define RSCR_BIT_OT_FAULT 7
`define RSCR_BIT_OT_WARN 6
`define RSCR_BIT_BAD_CMD 7
`define RSCR_BIT_BAD_DATA 6
`define RSCR_BIT_PEC 5
`define RSCR_BIT_MEM_CRC 4
`endif

// ---- hw/rscr_regs.v ----
// Status and configuration register bank of a step-down regulator.
//
// Operation
// - Word bit 11 shows power good low
// - Word low byte equals status byte
// - Status flags clear on write one
// - Output voltage status: bit7 overvoltage, bit4 undervoltage
// - Bit3 set on out-of-limit target write
// - Current status bit7 on overcurrent fault
// - Input status bit7 on input overvoltage
// - Thermal status: bit7 fault, bit6 warning
// - Comm status bits 7..4 for errors
// - Lock code blocks most register writes
// - Lock cleared by zero; others invalid
// - Hiccup interval field, default 01
// - Startup ramp field, default 00
// - Shutdown ramp field, default 00
// - Transition ramp field, default 00
// - Soft stop bit1, discharge bit0, off
// - Spread spectrum enable bit0, default on
// - Sync phase bit2, default one
// - Switching frequency bits 1:0, default 00
// - Loop network codes; bad capacitor invalid
// - Input overvoltage protect bit4, default on
// - Overcurrent retry select, default 11
// - Out-of-range target clamps to limit
`timescale 1ns/1ps
`default_nettype none
`include "rscr_defines.vh"

module rscr_regs (
	input wire clk_sys_i,
	input wire rstn_i,
	input wire wr_en_i,
	input wire [7:0] wr_addr_i,
	input wire [15:0] wr_data_i,
	input wire [7:0] rd_addr_i,
	output reg [15:0] rd_data_o,
	input wire [7:0] status_byte_i,
	input wire power_ok_low_flag_i,
	input wire [3:0] status_word_hi_i,
	input wire output_overvoltage_flag_i,
	input wire output_undervoltage_flag_i,
	input wire output_overcurrent_flag_i,
	input wire input_overvoltage_flag_i,
	input wire overheat_fault_flag_i,
	input wire overheat_warning_flag_i,
	input wire bad_command_flag_i,
	input wire bad_data_flag_i,
	input wire packet_check_failure_flag_i,
	input wire memory_crc_flag_i,
	input wire [7:0] vout_max_i,
	input wire [7:0] vout_min_i,
	output reg [7:0] vout_target_o,
	output wire write_locked_o,
	output reg [1:0] retry_interval_o,
	output reg [1:0] startup_ramp_rate_o,
	output reg [1:0] shutdown_ramp_rate_o,
	output reg [1:0] transition_ramp_rate_o,
	output reg soft_stop_enable_o,
	output reg discharge_enable_o,
	output reg spread_spectrum_enable_o,
	output reg sync_out_phase_sel_o,
	output reg [1:0] switching_freq_o,
	output reg [2:0] comp_capacitor_code_o,
	output reg [2:0] pole_capacitor_code_o,
	output reg [3:0] comp_resistor_code_o,
	output reg input_overvoltage_protect_enable_o,
	output reg [1:0] overcurrent_retry_select_o
);

	// ==========================================================
	// Write qualification
	reg [7:0] lock_reg;
	wire vout_ov_flag;
	wire vout_uv_flag;
	wire vout_limit_flag;
	wire iout_oc_flag;
	wire vin_ov_flag;
	wire ot_fault_flag;
	wire ot_warn_flag;
	wire bad_cmd_flag;
	wire bad_data_flag;
	wire pec_flag;
	wire mem_crc_flag;
	wire clr_vout;
	wire clr_iout;
	wire clr_vin;
	wire clr_therm;
	wire clr_comm;
	wire [7:0] wd;
	wire locked;
	wire wr_ok;
	wire lock_wr;
	wire lock_bad;
	wire loop_bad;
	wire tgt_hi;
	wire tgt_lo;
	wire vtgt_wr;

	assign wd = wr_data_i[7:0];
	assign locked = (lock_reg == `RSCR_LOCK_CODE);
	assign write_locked_o = locked;
	// Lock register and status registers stay writable while locked.
	assign wr_ok = wr_en_i & (~locked | (wr_addr_i == `RSCR_ADDR_LOCK) |
		((wr_addr_i >= `RSCR_ADDR_VOUT_STATUS) && (wr_addr_i <= `RSCR_ADDR_COMM_STATUS)));
	assign lock_wr = wr_en_i & (wr_addr_i == `RSCR_ADDR_LOCK);
	assign lock_bad = lock_wr & (wd != `RSCR_LOCK_CODE) & (wd != `RSCR_LOCK_CLEAR);
	assign loop_bad = wr_ok & (wr_addr_i == `RSCR_ADDR_LOOP) &
		((wr_data_i[9:7] == 3'h5) | (wr_data_i[9:7] == 3'h7));
	assign vtgt_wr = wr_ok & (wr_addr_i == `RSCR_ADDR_VOUT_CMD);
	assign tgt_hi = wd > vout_max_i;
	assign tgt_lo = wd < vout_min_i;

	// ==========================================================
	// Status register write decode for write-one clears
	assign clr_vout = wr_en_i & (wr_addr_i == `RSCR_ADDR_VOUT_STATUS);
	assign clr_iout = wr_en_i & (wr_addr_i == `RSCR_ADDR_IOUT_STATUS);
	assign clr_vin = wr_en_i & (wr_addr_i == `RSCR_ADDR_INPUT_STATUS);
	assign clr_therm = wr_en_i & (wr_addr_i == `RSCR_ADDR_THERM_STATUS);
	assign clr_comm = wr_en_i & (wr_addr_i == `RSCR_ADDR_COMM_STATUS);

	// ==========================================================
	// Sticky status flags, set wins over clear
	rscr_sticky_flag vout_ov_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(output_overvoltage_flag_i),
		.clear_i(clr_vout & wd[`RSCR_BIT_VOUT_OV]),
		.flag_o(vout_ov_flag)
	);

	rscr_sticky_flag vout_uv_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(output_undervoltage_flag_i),
		.clear_i(clr_vout & wd[`RSCR_BIT_VOUT_UV]),
		.flag_o(vout_uv_flag)
	);

	rscr_sticky_flag vout_limit_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(vtgt_wr & (tgt_hi | tgt_lo)),
		.clear_i(clr_vout & wd[`RSCR_BIT_VOUT_LIMIT]),
		.flag_o(vout_limit_flag)
	);

	rscr_sticky_flag iout_oc_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(output_overcurrent_flag_i),
		.clear_i(clr_iout & wd[`RSCR_BIT_IOUT_OC]),
		.flag_o(iout_oc_flag)
	);

	rscr_sticky_flag vin_ov_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(input_overvoltage_flag_i),
		.clear_i(clr_vin & wd[`RSCR_BIT_VIN_OV]),
		.flag_o(vin_ov_flag)
	);

	rscr_sticky_flag ot_fault_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(overheat_fault_flag_i),
		.clear_i(clr_therm & wd[`RSCR_BIT_OT_FAULT]),
		.flag_o(ot_fault_flag)
	);

	rscr_sticky_flag ot_warn_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(overheat_warning_flag_i),
		.clear_i(clr_therm & wd[`RSCR_BIT_OT_WARN]),
		.flag_o(ot_warn_flag)
	);

	rscr_sticky_flag bad_cmd_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(bad_command_flag_i | lock_bad | loop_bad),
		.clear_i(clr_comm & wd[`RSCR_BIT_BAD_CMD]),
		.flag_o(bad_cmd_flag)
	);

	rscr_sticky_flag bad_data_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(bad_data_flag_i),
		.clear_i(clr_comm & wd[`RSCR_BIT_BAD_DATA]),
		.flag_o(bad_data_flag)
	);

	rscr_sticky_flag pec_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(packet_check_failure_flag_i),
		.clear_i(clr_comm & wd[`RSCR_BIT_PEC]),
		.flag_o(pec_flag)
	);

	rscr_sticky_flag mem_crc_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.set_i(memory_crc_flag_i),
		.clear_i(clr_comm & wd[`RSCR_BIT_MEM_CRC]),
		.flag_o(mem_crc_flag)
	);

	// ==========================================================
	// Output voltage target with limit clamp
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			vout_target_o <= `RSCR_RST_VOUT_CMD;
		end else if (vtgt_wr) begin
			if (tgt_hi) begin
				vout_target_o <= vout_max_i;
			end else if (tgt_lo) begin
				vout_target_o <= vout_min_i;
			end else begin
				vout_target_o <= wd;
			end
		end
	end

	// ==========================================================
	// Configuration registers
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			lock_reg <= `RSCR_RST_LOCK;
			retry_interval_o <= `RSCR_RST_RETRY;
			startup_ramp_rate_o <= `RSCR_RST_RAMP;
			shutdown_ramp_rate_o <= `RSCR_RST_RAMP;
			transition_ramp_rate_o <= `RSCR_RST_RAMP;
			{soft_stop_enable_o, discharge_enable_o} <= `RSCR_RST_DISCHARGE;
			spread_spectrum_enable_o <= `RSCR_RST_SPREAD;
			sync_out_phase_sel_o <= `RSCR_RST_PHASE;
			switching_freq_o <= `RSCR_RST_FREQ;
			{comp_capacitor_code_o, pole_capacitor_code_o, comp_resistor_code_o} <= `RSCR_RST_LOOP;
			input_overvoltage_protect_enable_o <= `RSCR_RST_OVP_EN;
			overcurrent_retry_select_o <= `RSCR_RST_OCP_SEL;
		end else begin
			if (lock_wr && !lock_bad) begin
				lock_reg <= wd;
			end
			if (wr_ok) begin
				case (wr_addr_i)
					`RSCR_ADDR_RETRY: retry_interval_o <= wd[1:0];
					`RSCR_ADDR_START_RAMP: startup_ramp_rate_o <= wd[1:0];
					`RSCR_ADDR_STOP_RAMP: shutdown_ramp_rate_o <= wd[1:0];
					`RSCR_ADDR_TRANS_RAMP: transition_ramp_rate_o <= wd[1:0];
					`RSCR_ADDR_DISCHARGE: {soft_stop_enable_o, discharge_enable_o} <= wd[1:0];
					`RSCR_ADDR_SPREAD: spread_spectrum_enable_o <= wd[0];
					`RSCR_ADDR_FREQ: begin
						sync_out_phase_sel_o <= wd[2];
						switching_freq_o <= wd[1:0];
					end
					`RSCR_ADDR_LOOP: begin
						if (!loop_bad) begin
							comp_capacitor_code_o <= wr_data_i[9:7];
							pole_capacitor_code_o <= wr_data_i[6:4];
							comp_resistor_code_o <= wr_data_i[3:0];
						end
					end
					`RSCR_ADDR_PROTECT: begin
						input_overvoltage_protect_enable_o <= wd[4];
						overcurrent_retry_select_o <= wd[3:2];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Read multiplexer, registered, reserved bits zero
	reg [15:0] rd_next;
	always @* begin
		rd_next = 16'h0000;
		case (rd_addr_i)
			`RSCR_ADDR_STATUS_BYTE: rd_next = {8'h00, status_byte_i};
			`RSCR_ADDR_STATUS_WORD: rd_next = {status_word_hi_i, power_ok_low_flag_i, 3'h0,
				status_byte_i};
			`RSCR_ADDR_VOUT_CMD: rd_next = {8'h00, vout_target_o};
			`RSCR_ADDR_VOUT_STATUS: rd_next = {8'h00, vout_ov_flag, 2'h0, vout_uv_flag,
				vout_limit_flag, 3'h0};
			`RSCR_ADDR_IOUT_STATUS: rd_next = {8'h00, iout_oc_flag, 7'h00};
			`RSCR_ADDR_INPUT_STATUS: rd_next = {8'h00, vin_ov_flag, 7'h00};
			`RSCR_ADDR_THERM_STATUS: rd_next = {8'h00, ot_fault_flag, ot_warn_flag, 6'h00};
			`RSCR_ADDR_COMM_STATUS: rd_next = {8'h00, bad_cmd_flag, bad_data_flag, pec_flag,
				mem_crc_flag, 4'h0};
			`RSCR_ADDR_LOCK: rd_next = {8'h00, lock_reg};
			`RSCR_ADDR_RETRY: rd_next = {14'h0000, retry_interval_o};
			`RSCR_ADDR_START_RAMP: rd_next = {14'h0000, startup_ramp_rate_o};
			`RSCR_ADDR_STOP_RAMP: rd_next = {14'h0000, shutdown_ramp_rate_o};
			`RSCR_ADDR_TRANS_RAMP: rd_next = {14'h0000, transition_ramp_rate_o};
			`RSCR_ADDR_DISCHARGE: rd_next = {14'h0000, soft_stop_enable_o, discharge_enable_o};
			`RSCR_ADDR_SPREAD: rd_next = {15'h0000, spread_spectrum_enable_o};
			`RSCR_ADDR_FREQ: rd_next = {13'h0000, sync_out_phase_sel_o, switching_freq_o};
			`RSCR_ADDR_LOOP: rd_next = {6'h00, comp_capacitor_code_o, pole_capacitor_code_o,
				comp_resistor_code_o};
			`RSCR_ADDR_PROTECT: rd_next = {11'h000, input_overvoltage_protect_enable_o,
				overcurrent_retry_select_o, 2'h0};
			default: rd_next = 16'h0000;
		endcase
	end

	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rd_data_o <= 16'h0000;
		end else begin
			rd_data_o <= rd_next;
		end
	end

endmodule

// ==========================================================
// Sticky event flag, an event in the clear cycle keeps it set.
module rscr_sticky_flag (
	input wire clk_sys_i,
	input wire rstn_i,
	input wire set_i,
	input wire clear_i,
	output reg flag_o
);

	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (clear_i) begin
			flag_o <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ---- bench/rscr_regs_properties.sv ----
// Concurrent checks on the regulator register bank ports.
`timescale 1ns/1ps
`default_nettype none
module rscr_regs_properties (
	input wire clk_sys_i,
	input wire rstn_i,
	input wire wr_en_i,
	input wire [7:0] wr_addr_i,
	input wire [15:0] wr_data_i,
	input wire [7:0] rd_addr_i,
	input wire [15:0] rd_data_o,
	input wire [7:0] status_byte_i,
	input wire power_ok_low_flag_i,
	input wire output_overvoltage_flag_i,
	input wire [7:0] vout_max_i,
	input wire [7:0] vout_target_o,
	input wire write_locked_o,
	input wire [1:0] retry_interval_o,
	input wire [2:0] comp_capacitor_code_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	wire wr_c4 = wr_en_i && wr_addr_i == 8'hC4;
	wire wr_c5 = wr_en_i && wr_addr_i == 8'hC5;
	a_lock_engage: assert property (wr_c4 && wr_data_i[7:0] == 8'h5A |=> write_locked_o)
		else $error("lock code did not engage the lock");
	a_lock_release: assert property (wr_c4 && wr_data_i[7:0] == 8'h00 |=> !write_locked_o)
		else $error("zero lock write did not release the lock");
	a_locked_hold: assert property (write_locked_o && wr_c5 |=> $stable(retry_interval_o))
		else $error("locked write changed a field");
	a_retry_load: assert property (!write_locked_o && wr_c5 |=>
		retry_interval_o == $past(wr_data_i[1:0])) else $error("retry field not loaded");
	a_word_power_bit: assert property (rd_addr_i == 8'h79 |=>
		rd_data_o[11] == $past(power_ok_low_flag_i)) else $error("status word bit 11 wrong");
	a_word_low_byte: assert property (rd_addr_i == 8'h79 |=>
		rd_data_o[7:0] == $past(status_byte_i)) else $error("status word low byte wrong");
	a_ov_flag_set: assert property (output_overvoltage_flag_i ##1 rd_addr_i == 8'h7A |=>
		rd_data_o[7]) else $error("overvoltage flag not set");
	a_target_clamp: assert property (!write_locked_o && wr_en_i && wr_addr_i == 8'h21 &&
		wr_data_i[7:0] > vout_max_i |=> vout_target_o == $past(vout_max_i))
		else $error("target not clamped to maximum");
	a_cap_refused: assert property (wr_en_i && wr_addr_i == 8'hCC &&
		wr_data_i[9:7] == 3'b101 |=> $stable(comp_capacitor_code_o)) else $error("bad cap taken");
endmodule
bind rscr_regs rscr_regs_properties rscr_regs_properties_inst (.clk_sys_i, .rstn_i, .wr_en_i,
	.wr_addr_i, .wr_data_i, .rd_addr_i, .rd_data_o, .status_byte_i, .power_ok_low_flag_i,
	.output_overvoltage_flag_i, .vout_max_i, .vout_target_o, .write_locked_o,
	.retry_interval_o, .comp_capacitor_code_o);
`default_nettype wire

// ---- bench/rscr_host_model.sv ----
// Host bus controller model that writes and reads the register bank.
`timescale 1ns/1ps
`default_nettype none
module rscr_host_model (
	input wire logic clk_sys_i,
	input wire logic [15:0] rd_data_i,
	output logic wr_en_o = 1'b0,
	output logic [7:0] wr_addr_o = 8'h00,
	output logic [15:0] wr_data_o = 16'h0000,
	output logic [7:0] rd_addr_o = 8'h00
);
	// Released write lines show inverted values so stale data is never mistaken for valid.
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_sys_i);
		wr_en_o = 1'b1;
		wr_addr_o = a;
		wr_data_o = d;
		@(negedge clk_sys_i);
		wr_en_o = 1'b0;
		wr_addr_o = ~a;
		wr_data_o = ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk_sys_i);
		rd_addr_o = a;
		@(negedge clk_sys_i);
		d = rd_data_i;
	endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the regulator register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] status_byte_i = 8'h00;
	logic power_ok_low_flag_i = 1'b0;
	logic [3:0] status_word_hi_i = 4'h0;
	logic [9:0] ev = 10'h000;
	logic [7:0] vout_max_i = 8'h80;
	logic [7:0] vout_min_i = 8'h10;
	int bad_count = 0;
	int compares = 0;
	wire wr_en_i, write_locked_o, soft_stop_enable_o, discharge_enable_o, spread_spectrum_enable_o;
	wire sync_out_phase_sel_o, input_overvoltage_protect_enable_o;
	wire output_overvoltage_flag_i, output_undervoltage_flag_i, output_overcurrent_flag_i;
	wire input_overvoltage_flag_i, overheat_fault_flag_i, overheat_warning_flag_i;
	wire bad_command_flag_i, bad_data_flag_i, packet_check_failure_flag_i, memory_crc_flag_i;
	wire [7:0] wr_addr_i, rd_addr_i, vout_target_o;
	wire [15:0] wr_data_i, rd_data_o;
	wire [1:0] retry_interval_o, startup_ramp_rate_o, shutdown_ramp_rate_o, transition_ramp_rate_o;
	wire [1:0] switching_freq_o, overcurrent_retry_select_o;
	wire [2:0] comp_capacitor_code_o, pole_capacitor_code_o;
	wire [3:0] comp_resistor_code_o;
	logic [7:0] fa [10] = '{8'h7A, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7D, 8'h7E, 8'h7E, 8'h7E, 8'h7E};
	logic [15:0] fm [10] = '{16'h80, 16'h10, 16'h80, 16'h80, 16'h80, 16'h40, 16'h80, 16'h40,
		16'h20, 16'h10};
	logic [7:0] ca [7] = '{8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hCA, 8'hCB};
	logic [15:0] cm [7] = '{16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h1, 16'h7};
	assign {memory_crc_flag_i, packet_check_failure_flag_i, bad_data_flag_i, bad_command_flag_i,
		overheat_warning_flag_i, overheat_fault_flag_i, input_overvoltage_flag_i,
		output_overcurrent_flag_i, output_undervoltage_flag_i, output_overvoltage_flag_i} = ev;
	always #20 clk_sys_i = ~clk_sys_i;
	rscr_regs rscr_regs_inst (.clk_sys_i, .rstn_i, .wr_en_i, .wr_addr_i, .wr_data_i, .rd_addr_i,
		.rd_data_o, .status_byte_i, .power_ok_low_flag_i, .status_word_hi_i,
		.output_overvoltage_flag_i, .output_undervoltage_flag_i, .output_overcurrent_flag_i,
		.input_overvoltage_flag_i, .overheat_fault_flag_i, .overheat_warning_flag_i,
		.bad_command_flag_i, .bad_data_flag_i, .packet_check_failure_flag_i, .memory_crc_flag_i,
		.vout_max_i, .vout_min_i, .vout_target_o, .write_locked_o, .retry_interval_o,
		.startup_ramp_rate_o, .shutdown_ramp_rate_o, .transition_ramp_rate_o, .soft_stop_enable_o,
		.discharge_enable_o, .spread_spectrum_enable_o, .sync_out_phase_sel_o, .switching_freq_o,
		.comp_capacitor_code_o, .pole_capacitor_code_o, .comp_resistor_code_o,
		.input_overvoltage_protect_enable_o, .overcurrent_retry_select_o);
	rscr_host_model rscr_host_model_inst (.clk_sys_i, .rd_data_i(rd_data_o), .wr_en_o(wr_en_i),
		.wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i), .rd_addr_o(rd_addr_i));
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		rscr_host_model_inst.write_reg(a, d);
	endtask
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rscr_host_model_inst.read_reg(a, d);
		chk(n, d, exp);
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#(40 * 5000);
		bad_count++;
		close_out;
	end
	initial begin
		repeat (16) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		chk("dflt_a", 16'({overcurrent_retry_select_o, input_overvoltage_protect_enable_o,
			switching_freq_o, sync_out_phase_sel_o, spread_spectrum_enable_o}), 16'h0073);
		chk("dflt_b", 16'({discharge_enable_o, soft_stop_enable_o, transition_ramp_rate_o,
			shutdown_ramp_rate_o, startup_ramp_rate_o, retry_interval_o}), 16'h0001);
		$display("test defaults done");
		for (int i = 0; i < 7; i++) begin
			wr(ca[i], 16'hFFFF);
			rd_chk("cfg_ones", ca[i], cm[i]);
		end
		chk("cfg_ports", 16'({discharge_enable_o, soft_stop_enable_o, transition_ramp_rate_o,
			shutdown_ramp_rate_o, startup_ramp_rate_o, retry_interval_o}), 16'h03FF);
		chk("freq_ports", 16'({switching_freq_o, sync_out_phase_sel_o}), 16'h0007);
		for (int i = 0; i < 7; i++) begin
			wr(ca[i], 16'h0000);
			rd_chk("cfg_zero", ca[i], 16'h0000);
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'hCE, 16'(i << 2));
			chk("protect", 16'({input_overvoltage_protect_enable_o, overcurrent_retry_select_o}), 16'(i));
		end
		$display("test config done");
		status_byte_i = 8'hA5;
		power_ok_low_flag_i = 1'b1;
		status_word_hi_i = 4'h9;
		rd_chk("word_low_pg", 8'h79, 16'h98A5);
		rd_chk("byte", 8'h78, 16'h00A5);
		rd_chk("unmapped", 8'h00, 16'h0000);
		power_ok_low_flag_i = 1'b0;
		rd_chk("word_high_pg", 8'h79, 16'h90A5);
		for (int i = 0; i < 10; i++) begin
			ev[i] = 1'b1;
			rd_chk("flag_set", fa[i], fm[i]);
			ev = 10'h000;
			wr(fa[i], 16'h0000);
			rd_chk("flag_keep", fa[i], fm[i]);
			wr(fa[i], fm[i]);
			rd_chk("flag_clear", fa[i], 16'h0000);
		end
		$display("test flags done");
		wr(8'h21, 16'h0090);
		chk("clamp_max", 16'(vout_target_o), 16'h0080);
		rd_chk("warn_max", 8'h7A, 16'h0008);
		wr(8'h7A, 16'h0008);
		wr(8'h21, 16'h0005);
		chk("clamp_min", 16'(vout_target_o), 16'h0010);
		rd_chk("warn_min", 8'h7A, 16'h0008);
		wr(8'h7A, 16'h0008);
		wr(8'h21, 16'h0040);
		chk("in_range", 16'(vout_target_o), 16'h0040);
		rd_chk("no_warn", 8'h7A, 16'h0000);
		$display("test clamp done");
		wr(8'hC4, 16'h005A);
		chk("locked", 16'(write_locked_o), 16'h0001);
		wr(8'hC5, 16'h0002);
		chk("lock_hold", 16'(retry_interval_o), 16'h0000);
		wr(8'hC4, 16'h0033);
		rd_chk("lock_bad", 8'h7E, 16'h0080);
		chk("still_lock", 16'(write_locked_o), 16'h0001);
		wr(8'h7E, 16'h0080);
		rd_chk("exempt_clr", 8'h7E, 16'h0000);
		wr(8'hC4, 16'h0000);
		wr(8'hC5, 16'h0002);
		chk("unlocked", 16'({write_locked_o, retry_interval_o}), 16'h0002);
		$display("test lock done");
		wr(8'hCC, 16'hFD23);
		rd_chk("loop_rd", 8'hCC, 16'h0123);
		chk("loop_ports", 16'({comp_capacitor_code_o, pole_capacitor_code_o,
			comp_resistor_code_o}), 16'h0123);
		wr(8'hCC, 16'h02A0);
		wr(8'hCC, 16'h0380);
		rd_chk("loop_keep", 8'hCC, 16'h0123);
		rd_chk("loop_bad", 8'h7E, 16'h0080);
		$display("test loop done");
		close_out;
	end
endmodule
`default_nettype wire
